/* File: bvs_assertions.sv */
// checker for the buck2 setpoint register bank
// assumes it is bound to the bank's top ports, one clock domain
`timescale 1ns/10ps
module bvs_assertions
   import bvs_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        reset_n,
   // watched ports
   input wire logic        range_strap,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic [6:0]  target_code,
   input wire logic [11:0] target_mv,
   input wire logic        target_valid
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // answer cycle of a setpoint read
   sequence s_rd_done;
      $past(reg_rd) && ($past(reg_addr) <= BVS_OFS_SLEEP);
   endsequence
   // read data only in the answer cycle
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
   property p_bit7;
      s_rd_done |-> reg_rdata[7] == 1'b0;
   endproperty
   a_bit7: assert property (p_bit7) else $error("bit 7 set");
   property p_bit6;
      s_rd_done |-> !target_valid || reg_rdata[6] == target_code[6];
   endproperty
   a_bit6: assert property (p_bit6) else $error("bit 6 wrong");
   property p_mv_low;
      target_valid && !target_code[6] |->
         target_mv == 12'd400 + 12'd25 * target_code[5:0];
   endproperty
   a_mv_low: assert property (p_mv_low) else $error("low mv");
   property p_mv_high;
      target_valid && target_code[6] |->
         target_mv == 12'd800 + 12'd50 * target_code[5:0];
   endproperty
   a_mv_high: assert property (p_mv_high) else $error("high mv");
   property p_valid_hold;
      target_valid |=> target_valid;
   endproperty
   a_valid_hold: assert property (p_valid_hold) else $error("valid fell");
   property p_range_hold;
      target_valid |=> $stable(target_code[6]);
   endproperty
   a_range_hold: assert property (p_range_hold) else $error("range");
   // target moves only two edges after a write
   property p_tgt_cause;
      $past(target_valid) && $changed(target_code) |-> $past(reg_wr, 2);
   endproperty
   a_tgt_cause: assert property (p_tgt_cause) else $error("target");
endmodule // bvs_assertions
bind bvs_setpoint_regs bvs_assertions chk (.clock, .reset_n, .range_strap,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .target_code,
   .target_mv, .target_valid);

/* File: bvs_pkg.sv */
// package for the buck2 setpoint register bank
// assumes a plain address/strobe register port and a 100 MHz clock
package bvs_pkg;

   // register offsets
   localparam logic [7:0] BVS_OFS_NORMAL  = 8'h00;
   localparam logic [7:0] BVS_OFS_STANDBY = 8'h01;
   localparam logic [7:0] BVS_OFS_SLEEP   = 8'h02;
   localparam logic [7:0] BVS_OFS_MODE    = 8'h03;
   localparam logic [7:0] BVS_OFS_TARGET  = 8'h04;

   // field layout of a setpoint code
   localparam int BVS_RANGE_BIT = 6;
   localparam int BVS_CODE_W    = 7;
   localparam int BVS_STEP_W    = 6;

   // reset values of the six-bit step fields
   localparam logic [5:0] BVS_RST_STEP = 6'h00;

   // voltage mapping in millivolts
   localparam logic [11:0] BVS_LOW_BASE_MV  = 12'd400;
   localparam logic [11:0] BVS_LOW_STEP_MV  = 12'd25;
   localparam logic [11:0] BVS_HIGH_BASE_MV = 12'd800;
   localparam logic [11:0] BVS_HIGH_STEP_MV = 12'd50;

   // operating modes of the regulator
   typedef enum logic [1:0] {
      BVS_MODE_NORMAL,
      BVS_MODE_STANDBY,
      BVS_MODE_SLEEP
   } bvs_mode_t;

   // one register access from software
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bvs_bus_t;

   // regulator target for the analog loop
   typedef struct packed {
      logic [6:0]  code;
      logic [11:0] mv;
   } bvs_target_t;

endpackage

/* File: bvs_range_latch.sv */
// catches the range strap once after reset release
// assumes the strap is stable while reset is low and a little after
`timescale 1ns/10ps
module bvs_range_latch
   import bvs_pkg::*;
(
   // clock and reset
   input  wire logic clock,
   input  wire logic reset_n,
   // strap from default or one-time configuration
   input  wire logic range_strap,
   // captured range and its valid flag
   output logic      range_bit,
   output logic      range_valid
);

   typedef struct packed {
      logic range_bit;
      logic range_valid;
   } bvs_latch_state_t;

   bvs_latch_state_t state;
   bvs_latch_state_t next_state;

   // capture on the first clocked edge after release
   always_comb begin
      next_state = state;
      if (!state.range_valid) begin
         next_state.range_bit   = range_strap;
         next_state.range_valid = 1'b1;
      end
   end

   // state register, constant under reset
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign range_bit   = state.range_bit;
   assign range_valid = state.range_valid;

endmodule // bvs_range_latch

/* File: bvs_setpoint_regs.sv */
// buck2 setpoint register bank with mode-driven target output
// assumes single-cycle strobes from a master that never waits
`timescale 1ns/10ps
module bvs_setpoint_regs
   import bvs_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // configuration strap for the range bit
   input  wire logic        range_strap,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // regulator target
   output logic      [6:0]  target_code,
   output logic      [11:0] target_mv,
   output logic             target_valid
);

   logic range_bit;
   logic range_valid;

   // range strap capture after reset
   bvs_range_latch u_range (
      .clock       (clock),
      .reset_n     (reset_n),
      .range_strap (range_strap),
      .range_bit   (range_bit),
      .range_valid (range_valid)
   );

   typedef struct packed {
      logic [5:0]  normal_step;
      logic [5:0]  standby_step;
      logic [5:0]  sleep_step;
      bvs_mode_t   mode;
      logic [7:0]  rdata;
      bvs_target_t target;
      logic        target_valid;
   } bvs_regs_state_t;

   bvs_regs_state_t state;
   bvs_regs_state_t next_state;
   bvs_bus_t        bus;

   // code to millivolts, linear scaling per range
   function automatic logic [11:0] bvs_code_to_mv(input logic [6:0] code);
      logic [11:0] step;
      step = {6'h00, code[5:0]};
      if (code[BVS_RANGE_BIT]) begin
         bvs_code_to_mv = BVS_HIGH_BASE_MV
                        + 12'(step * BVS_HIGH_STEP_MV);
      end else begin
         bvs_code_to_mv = BVS_LOW_BASE_MV
                        + 12'(step * BVS_LOW_STEP_MV);
      end
   endfunction

   // read value of any offset, unmapped reads zero
   function automatic logic [7:0] bvs_read(input bvs_regs_state_t s,
                                           input logic [7:0] a,
                                           input logic rb);
      case (a)
         BVS_OFS_NORMAL:  bvs_read = {1'b0, rb, s.normal_step};
         BVS_OFS_STANDBY: bvs_read = {1'b0, rb, s.standby_step};
         BVS_OFS_SLEEP:   bvs_read = {1'b0, rb, s.sleep_step};
         BVS_OFS_MODE:    bvs_read = {6'h00, s.mode};
         BVS_OFS_TARGET:  bvs_read = {1'b0, s.target.code};
         default:         bvs_read = 8'h00;
      endcase
   endfunction

   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // register writes, reads and target selection
   always_comb begin
      logic [6:0] sel;
      sel        = 7'h00;
      next_state = state;
      // setpoint writes touch only the six step bits; bits 7 and 6 are ignored
      if (bus.wr) begin
         case (bus.addr)
            BVS_OFS_NORMAL:
               next_state.normal_step  = bus.wdata[5:0];
            BVS_OFS_STANDBY:
               next_state.standby_step = bus.wdata[5:0];
            BVS_OFS_SLEEP:
               next_state.sleep_step   = bus.wdata[5:0];
            BVS_OFS_MODE: begin
               if (bus.wdata[1:0] <= 2'(BVS_MODE_SLEEP)) begin
                  next_state.mode = bvs_mode_t'(bus.wdata[1:0]);
               end
            end
            default: ;
         endcase
      end
      // read data stand in the cycle after the strobe only
      if (bus.rd) begin
         next_state.rdata = bvs_read(state, bus.addr, range_bit);
      end else begin
         next_state.rdata = 8'h00;
      end
      // pick the field of the active mode
      case (state.mode)
         BVS_MODE_STANDBY: sel = {range_bit, state.standby_step};
         BVS_MODE_SLEEP:   sel = {range_bit, state.sleep_step};
         default:          sel = {range_bit, state.normal_step};
      endcase
      next_state.target.code  = sel;
      next_state.target.mv    = bvs_code_to_mv(sel);
      next_state.target_valid = range_valid;
   end

   // state register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state              <= '0;
         state.normal_step  <= BVS_RST_STEP;
         state.standby_step <= BVS_RST_STEP;
         state.sleep_step   <= BVS_RST_STEP;
         state.mode         <= BVS_MODE_NORMAL;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata    = state.rdata;
   assign target_code  = state.target.code;
   assign target_mv    = state.target.mv;
   assign target_valid = state.target_valid;

endmodule // bvs_setpoint_regs

/* File: testbench.sv */
// testbench for the buck2 setpoint register bank
// assumes the checker is bound and the clock runs at 100 MHz
`timescale 1ns/10ps
module testbench
   import bvs_pkg::*;
;
   logic        clock = 0, reset_n = 0, range_strap = 0;
   logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic        reg_wr = 0, reg_rd = 0, target_valid;
   logic [6:0]  target_code;
   logic [11:0] target_mv;
   int          failures = 0, n_checks = 0;
   // setpoints kept above 0.6 V; high range only for 2.000-3.300 V
   logic [5:0]  st_lo [3] = '{6'h0A, 6'h15, 6'h3F};
   logic [5:0]  st_hi [3] = '{6'h18, 6'h25, 6'h32};
   // clock
   always #5 clock = ~clock;
   bvs_setpoint_regs uut (.clock, .reset_n, .range_strap, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .target_code, .target_mv,
      .target_valid);
   // shared helpers
   function automatic logic [5:0] step_of(input logic r, input int i);
      return r ? st_hi[i] : st_lo[i];
   endfunction
   task chk(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk({4'h0, reg_rdata}, {4'h0, exp});
   endtask
   task do_reset(input logic r);
      @(posedge clock);
      reset_n <= 1'b0;
      range_strap <= r;
      repeat (8) @(posedge clock);
      chk({11'h000, target_valid}, 12'h000);
      reset_n <= 1'b1;
      repeat (2) @(posedge clock);
      #1 chk({11'h000, target_valid}, 12'h001);
      chk({5'h00, target_code}, {5'h00, r, BVS_RST_STEP});
   endtask
   // fields written with bits 7 and 6 set, then read back
   task t_fields(input logic r);
      for (int i = 0; i < 3; i++) begin
         wr(8'(i), {2'b11, step_of(r, i)});
      end
      wr(BVS_OFS_MODE, 8'h03);
      for (int i = 0; i < 3; i++) begin
         rd_chk(8'(i), {1'b0, r, step_of(r, i)});
      end
      rd_chk(BVS_OFS_MODE, 8'h00);
      rd_chk(8'h05, 8'h00);
      $display("fields range %0d done", r);
   endtask
   // each mode selects its own field as target
   task t_modes(input logic r);
      for (int m = 0; m < 3; m++) begin
         wr(BVS_OFS_MODE, 8'(m));
         repeat (2) @(posedge clock);
         #1 chk({5'h00, target_code}, {5'h00, r, step_of(r, m)});
         chk(target_mv, r ? 12'd800 + 12'd50 * step_of(r, m)
                          : 12'd400 + 12'd25 * step_of(r, m));
         rd_chk(BVS_OFS_MODE, 8'(m));
         rd_chk(BVS_OFS_TARGET, {1'b0, r, step_of(r, m)});
      end
      $display("modes range %0d done", r);
   endtask
   task close_out;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // both strap values, each after a fresh reset
   initial begin
      do_reset(1'b0);
      t_fields(1'b0);
      t_modes(1'b0);
      do_reset(1'b1);
      t_fields(1'b1);
      t_modes(1'b1);
      close_out();
   end
endmodule // testbench
